// >>> rtl/rbeo_rx_backend.v
`timescale 1ns/100ps
`include "rbeo_consts.vh"
module rbeo_rx_backend (
  // Clock, reset, enable
  input wire mclk_in,
  input wire rst_n_in,
  input wire ce_in,
  // AXI4-Lite register slave
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // Framed characters on the recovered character strobe
  input wire rec_char_valid_in,
  input wire [9:0] raw_char_bits_in,
  input wire [7:0] dec_data_in,
  input wire [2:0] dec_status_in,
  input wire char_boundary_in,
  input wire pll_locked_in,
  // Reference character tick
  input wire ref_char_tick_in,
  // Output register
  output reg [7:0] rx_data_bits_out,
  output reg [2:0] rx_status_bits_out,
  output reg rx_char_valid_out,
  output reg rx_output_clock_out,
  // Configuration and power
  output wire framing_char_sel_out,
  output wire [1:0] framer_mode_sel_out,
  output wire framer_enable_out,
  output wire rx_pll_enable_out,
  output wire serial_driver1_enable_out,
  output wire serial_driver2_enable_out,
  output wire tx_logic_power_out
);
  localparam S_OFF = 2'd0;
  localparam S_START = 2'd1;
  localparam S_WAIT = 2'd2;
  localparam S_RUN = 2'd3;

  reg [1:0] rst_sync;
  wire rst_n = rst_sync[1];

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // Register slave
  reg [10:0] ctrl;
  reg aw_got;
  reg w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [1:0] st;
  reg [4:0] diff;
  reg [7:0] pass_cnt;
  reg [7:0] fail_cnt;
  wire [3:0] eb_level;

  assign s_axi_awready_out = ce_in & ~aw_got & ~s_axi_bvalid_out;
  assign s_axi_wready_out = ce_in & ~w_got & ~s_axi_bvalid_out;
  assign s_axi_arready_out = ce_in & ~s_axi_rvalid_out;

  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] ctrl_wide = {21'h0, ctrl};
  wire [31:0] ctrl_new = (ctrl_wide & ~wmask) | (w_data & wmask);

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `RBEO_CTRL_RESET; // see RULE_09
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (aw_got && w_got) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        if (aw_addr == `RBEO_ADDR_CTRL) begin
          ctrl <= ctrl_new[10:0]; // see RULE_24
          s_axi_bresp_out <= 2'b00;
        end else if (aw_addr == `RBEO_ADDR_STATUS || aw_addr == `RBEO_ADDR_LOOPS) begin
          s_axi_bresp_out <= 2'b00;
        end else begin
          s_axi_bresp_out <= 2'b11;
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= 2'b00;
    end else if (ce_in) begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= 2'b00;
        case (s_axi_araddr_in)
          `RBEO_ADDR_CTRL: s_axi_rdata_out <= ctrl_wide;
          `RBEO_ADDR_STATUS: s_axi_rdata_out <= {19'h0, diff, eb_level, 1'b0,
                                                 pll_locked_in, st};
          `RBEO_ADDR_LOOPS: s_axi_rdata_out <= {16'h0000, fail_cnt, pass_cnt};
          default: begin
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= 2'b11;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // Configuration fan-out
  wire st_en = ctrl[`RBEO_C_SELFTEST];
  wire decode = ctrl[`RBEO_C_DECODE];
  wire refmode = ctrl[`RBEO_C_REFMODE];
  wire half = ctrl[`RBEO_C_HALF];
  assign framing_char_sel_out = ctrl[`RBEO_C_FRCHAR];
  assign framer_mode_sel_out = ctrl[`RBEO_C_FRMODE];
  assign framer_enable_out = ctrl[`RBEO_C_FREN];
  assign rx_pll_enable_out = ctrl[`RBEO_C_PLLPWR]; // see RULE_15
  assign serial_driver1_enable_out = ctrl[`RBEO_C_DRV1];
  assign serial_driver2_enable_out = ctrl[`RBEO_C_DRV2];
  assign tx_logic_power_out = ctrl[`RBEO_C_DRV1] | ctrl[`RBEO_C_DRV2]; // see RULE_15

  function is_framing;
    input [9:0] raw;
    input sel;
    begin
      if (sel) begin
        is_framing = raw == `RBEO_K285_A || raw == `RBEO_K285_B;
      end else begin
        is_framing = raw[7:0] == `RBEO_COMMA_A || raw[7:0] == `RBEO_COMMA_B;
      end
    end
  endfunction

  function [8:0] lfsr_step;
    input [8:0] p;
    begin
      lfsr_step = {p[7:0], ~(p[8] ^ p[4])};
    end
  endfunction

  // Expected character: data lfsr[7:0], special when lfsr[8], violation slots when top bits set
  function char_match;
    input [8:0] p;
    input [7:0] d;
    input [2:0] s;
    begin
      if (p[8] && p[7:4] == 4'hf) begin
        char_match = s == `RBEO_DST_INVALID || s == `RBEO_DST_RDERR;
      end else begin
        char_match = d == p[7:0] && s == (p[8] ? `RBEO_DST_SPECIAL : `RBEO_DST_DATA);
      end
    end
  endfunction

  // Self-test checker
  wire comdet = char_boundary_in & is_framing(raw_char_bits_in, ctrl[`RBEO_C_FRCHAR]); // see RULE_20
  reg [8:0] lfsr;
  reg loop_err;
  reg [3:0] hold;
  reg [1:0] next_st;
  reg [8:0] next_lfsr;
  reg [4:0] next_diff;
  reg next_loop_err;
  reg [2:0] bist_code;
  reg pass_ev;
  reg fail_ev;
  wire eb_fault;
  wire [8:0] lfsr_adv = lfsr_step(lfsr);
  wire hit = char_match(lfsr, dec_data_in, dec_status_in);
  wire start_char = dec_data_in == 8'h00 && dec_status_in == `RBEO_DST_DATA;

  always @* begin
    next_st = st;
    next_lfsr = lfsr;
    next_diff = diff;
    next_loop_err = loop_err;
    bist_code = `RBEO_BST_START;
    pass_ev = 1'b0;
    fail_ev = 1'b0;
    case (st)
      S_OFF: begin
        next_st = S_WAIT;
        next_lfsr = `RBEO_LFSR_START; // see RULE_03
      end
      S_START: begin
        if (hold == 4'h0) begin
          next_st = S_WAIT;
          next_lfsr = `RBEO_LFSR_START;
        end
      end
      S_WAIT: begin
        bist_code = `RBEO_BST_WAIT;
        if (start_char) begin // see RULE_07
          next_st = S_RUN;
          next_lfsr = lfsr_step(`RBEO_LFSR_START);
          next_diff = 5'h00;
          next_loop_err = 1'b0;
          bist_code = `RBEO_BST_MATCH;
        end
      end
      S_RUN: begin
        next_lfsr = lfsr_adv; // see RULE_02
        if (hit) begin // see RULE_04
          bist_code = `RBEO_BST_MATCH;
          if (diff != 5'h00) begin
            next_diff = diff - 5'h01;
          end
        end else begin
          bist_code = `RBEO_BST_MISS;
          next_loop_err = 1'b1;
          next_diff = diff + 5'h01;
        end
        if (!hit && diff == `RBEO_ABORT_MARGIN) begin // see RULE_06
          next_st = S_WAIT;
          next_lfsr = `RBEO_LFSR_START;
          bist_code = `RBEO_BST_WAIT;
        end else if (lfsr_adv == `RBEO_LFSR_START) begin // see RULE_05
          next_st = S_WAIT;
          pass_ev = hit & ~loop_err;
          fail_ev = ~(hit & ~loop_err);
          bist_code = (hit && !loop_err) ? `RBEO_BST_PASS : `RBEO_BST_FAIL;
        end
      end
      default: begin
        next_st = S_OFF;
      end
    endcase
  end

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_OFF; // see RULE_16
      lfsr <= `RBEO_LFSR_START;
      diff <= 5'h00;
      loop_err <= 1'b0;
      hold <= 4'h0;
      pass_cnt <= 8'h00;
      fail_cnt <= 8'h00;
    end else if (ce_in) begin
      if (eb_fault) begin
        hold <= `RBEO_RECENTER_CHARS;
      end else if (rec_char_valid_in && hold != 4'h0) begin
        hold <= hold - 4'h1;
      end
      if (!st_en) begin // see RULE_01
        st <= S_OFF;
      end else if (!pll_locked_in || eb_fault) begin
        st <= S_START;
      end else if (rec_char_valid_in) begin
        st <= next_st;
        lfsr <= next_lfsr;
        diff <= next_diff;
        loop_err <= next_loop_err;
        if (pass_ev) begin
          pass_cnt <= pass_cnt + 8'h01;
        end
        if (fail_ev) begin
          fail_cnt <= fail_cnt + 8'h01;
        end
      end
    end
  end

  // Write-side stage: decoded or raw mapping, self-test status override
  wire [2:0] base_status = decode ? dec_status_in :
                           {comdet, raw_char_bits_in[0], raw_char_bits_in[1]}; // see RULE_19
  wire [7:0] base_data = decode ? dec_data_in : raw_char_bits_in[9:2]; // see RULE_18
  wire checking = st_en && st != S_OFF;
  reg [10:0] stage;
  reg stage_fr;
  reg stage_v;

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 11'h000;
      stage_fr <= 1'b0;
      stage_v <= 1'b0;
    end else if (ce_in) begin
      stage_v <= rec_char_valid_in;
      if (rec_char_valid_in) begin
        stage <= {checking ? bist_code : base_status, base_data}; // see RULE_23
        stage_fr <= comdet;
      end
    end
  end

  wire [10:0] eb_rdata;
  wire eb_rvalid;

  rbeo_elastic u_eb (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .en_in(refmode), // see RULE_10
    .wr_in(stage_v),
    .wdata_in(stage),
    .wframe_in(stage_fr),
    .rd_in(ref_char_tick_in), // see RULE_11
    .fill_in(decode ? `RBEO_FILL_DEC : `RBEO_FILL_BYP),
    .rdata_out(eb_rdata),
    .rvalid_out(eb_rvalid),
    .fault_out(eb_fault),
    .level_out(eb_level)
  );

  // Output register and receive clock
  wire ld_rec = ~refmode & stage_v; // see RULE_14
  wire ld_ref = refmode & eb_rvalid;
  wire fr_on = ctrl[`RBEO_C_FREN];
  wire ll = fr_on & (ctrl[`RBEO_C_FRMODE] == `RBEO_FR_LOWLAT);
  wire mb = fr_on & (ctrl[`RBEO_C_FRMODE] != `RBEO_FR_LOWLAT);
  wire wrong = ld_rec & half & stage_fr & rx_output_clock_out;
  reg [10:0] hold_r;
  reg dly;
  reg bump;

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_bits_out <= 8'h00;
      rx_status_bits_out <= 3'b000;
      rx_char_valid_out <= 1'b0;
      rx_output_clock_out <= 1'b0;
      hold_r <= 11'h000;
      dly <= 1'b0;
      bump <= 1'b0;
    end else if (ce_in) begin
      rx_char_valid_out <= ld_rec | ld_ref;
      bump <= 1'b0;
      if (bump) begin
        rx_output_clock_out <= 1'b1;
      end else if (ld_ref || ld_rec) begin
        if (!half) begin
          rx_output_clock_out <= 1'b1;
        end else if (wrong && (ll || (mb && dly))) begin
          rx_output_clock_out <= 1'b0; // see RULE_21
          bump <= 1'b1;
        end else begin
          rx_output_clock_out <= ~rx_output_clock_out;
        end
      end else if (!half) begin
        rx_output_clock_out <= 1'b0;
      end
      if (ld_ref) begin
        {rx_status_bits_out, rx_data_bits_out} <= eb_rdata;
      end else if (ld_rec) begin
        if (wrong && mb && !dly) begin
          dly <= 1'b1; // see RULE_22
          hold_r <= stage;
        end else if (wrong && mb && dly) begin
          dly <= 1'b0;
          {rx_status_bits_out, rx_data_bits_out} <= stage;
        end else if (dly) begin
          hold_r <= stage;
          {rx_status_bits_out, rx_data_bits_out} <= hold_r;
        end else begin
          {rx_status_bits_out, rx_data_bits_out} <= stage;
        end
      end
      if (!mb) begin
        dly <= 1'b0;
      end
    end
  end
endmodule

// >>> rtl/rbeo_consts.vh
`ifndef RBEO_CONSTS_VH
`define RBEO_CONSTS_VH
// Operation
// RULE_01: Setting the self-test enable bit turns the checker into an LFSR pattern checker.
// RULE_02: Checker LFSR repeats a fixed loop matching the far transmitter generator.
// RULE_03: On first seeing self-test enabled, preset the LFSR to loop start D0.0.
// RULE_04: Compare each character once synchronised; loop violations are not errors.
// RULE_05: Loop end shows 010b or 100b for one character, decoded or bypassed.
// RULE_06: Errors exceeding matches by 16 abort and rewind the LFSR to D0.0; the code aborts only on the next miss after diff reaches 16.
// RULE_07: Far transmitter sends 16 sync characters before each pass in reference mode.
// RULE_08: Host avoids the low-latency framer during self-test and frames first.
// RULE_09: Device reset clears the self-test enable on every channel.
// RULE_10: Elasticity buffer is 10 deep, 11 wide, bypassed in recovered-clock mode.
// RULE_11: Reference mode drives a buffered or divided delayed output clock via the buffer.
// RULE_12: Buffer inserts K28.5 or deletes framing only while a framing char is held.
// RULE_13: Far transmitter sends framing characters often enough to avoid slips.
// RULE_14: Recovered-clock output neither adds nor deletes characters and skips the buffer.
// RULE_15: PLL power bit low disables receive analog; both drivers off powers down transmit.
// RULE_16: Reset initialises all state and sets buffer pointers a nominal offset apart.
// RULE_17: After reset the host enables channels and resets the boundary-scan controller.
// RULE_18: Output bus is 8 data and 3 status bits, carried unchanged in decoder mode.
// RULE_19: Bypass maps framing flag, then raw bits a,b and c,d,e,i,f,g,h,j.
// RULE_20: Framing flag is high only for the selected framing char on the boundary.
// RULE_21: Low-latency framer at half rate stretches the clock so rising edge meets flag.
// RULE_22: Multi-byte framers shift one pipeline stage; framer off means no adjustment.
// RULE_23: Decoder mode status shows 000b for data and 001b for special codes.
// RULE_24: Bypass select 0 gives raw output, 1 enables decoding.
`define RBEO_ADDR_CTRL 8'h00
`define RBEO_ADDR_STATUS 8'h04
`define RBEO_ADDR_LOOPS 8'h08
`define RBEO_CTRL_RESET 11'h002
`define RBEO_C_SELFTEST 0
`define RBEO_C_DECODE 1
`define RBEO_C_FRCHAR 2
`define RBEO_C_FRMODE 4:3
`define RBEO_C_FREN 5
`define RBEO_C_HALF 6
`define RBEO_C_REFMODE 7
`define RBEO_C_PLLPWR 8
`define RBEO_C_DRV1 9
`define RBEO_C_DRV2 10
`define RBEO_EB_DEPTH 4'ha
`define RBEO_EB_NOMINAL 4'h5
`define RBEO_EB_LOW 4'h2
`define RBEO_EB_HIGH 4'h8
`define RBEO_RECENTER_CHARS 4'h9
`define RBEO_ABORT_MARGIN 5'h10
`define RBEO_LFSR_START 9'h000
`define RBEO_FILL_DEC 11'h1bc
`define RBEO_FILL_BYP 11'h45f
`define RBEO_COMMA_A 8'h7c
`define RBEO_COMMA_B 8'h83
`define RBEO_K285_A 10'h17c
`define RBEO_K285_B 10'h283
`define RBEO_FR_LOWLAT 2'b00
`define RBEO_DST_DATA 3'b000
`define RBEO_DST_SPECIAL 3'b001
`define RBEO_DST_RDERR 3'b110
`define RBEO_DST_INVALID 3'b111
`define RBEO_BST_MATCH 3'b001
`define RBEO_BST_PASS 3'b010
`define RBEO_BST_WAIT 3'b011
`define RBEO_BST_FAIL 3'b100
`define RBEO_BST_MISS 3'b101
`define RBEO_BST_START 3'b111
`endif

// >>> rtl/rbeo_elastic.v
`timescale 1ns/100ps
`include "rbeo_consts.vh"
module rbeo_elastic (
  // Clock and control
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire en_in,
  // Write side
  input wire wr_in,
  input wire [10:0] wdata_in,
  input wire wframe_in,
  // Read side
  input wire rd_in,
  input wire [10:0] fill_in,
  output reg [10:0] rdata_out,
  output reg rvalid_out,
  output reg fault_out,
  output reg [3:0] level_out
);
  reg [10:0] mem [0:9];
  reg [9:0] mark;
  reg [9:0] vld;
  reg [3:0] wp;
  reg [3:0] rp;
  reg [3:0] nfr;
  integer i;

  function [3:0] inc;
    input [3:0] p;
    begin
      inc = (p == `RBEO_EB_DEPTH - 4'h1) ? 4'h0 : p + 4'h1;
    end
  endfunction

  wire do_wr = wr_in & en_in;
  wire do_rd = rd_in & en_in;
  wire empty = level_out == 4'h0;
  wire full = level_out == `RBEO_EB_DEPTH;
  wire del = do_wr & wframe_in & (nfr != 4'h0) & (level_out >= `RBEO_EB_HIGH); // see RULE_12
  wire ins = do_rd & mark[rp] & (level_out <= `RBEO_EB_LOW); // see RULE_12
  wire ovf = do_wr & full & ~del;
  wire unf = do_rd & empty;
  wire push = do_wr & ~del & ~full;
  wire pop = do_rd & ~empty & ~ins;
  wire [3:0] fr_up = (push & wframe_in) ? 4'h1 : 4'h0;
  wire [3:0] fr_dn = (pop & mark[rp]) ? 4'h1 : 4'h0;
  wire [3:0] lv_up = push ? 4'h1 : 4'h0;
  wire [3:0] lv_dn = pop ? 4'h1 : 4'h0;

  always @(posedge clk_in) begin
    if (ce_in && push) begin
      mem[wp] <= wdata_in;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp <= `RBEO_EB_NOMINAL; // see RULE_16
      rp <= 4'h0;
      level_out <= `RBEO_EB_NOMINAL;
      nfr <= `RBEO_EB_NOMINAL;
      mark <= 10'h3ff;
      vld <= 10'h000;
      rdata_out <= 11'h000;
      rvalid_out <= 1'b0;
      fault_out <= 1'b0;
    end else if (ce_in) begin
      rvalid_out <= do_rd;
      fault_out <= ovf | unf;
      if (do_rd) begin
        rdata_out <= (ins || empty || !vld[rp]) ? fill_in : mem[rp];
      end
      if (ovf || unf) begin
        wp <= `RBEO_EB_NOMINAL;
        rp <= 4'h0;
        level_out <= `RBEO_EB_NOMINAL;
        nfr <= `RBEO_EB_NOMINAL;
        mark <= 10'h3ff;
        vld <= 10'h000;
      end else begin
        for (i = 0; i < 10; i = i + 1) begin
          if (push && wp == i) begin
            mark[i] <= wframe_in;
            vld[i] <= 1'b1;
          end
        end
        if (push) begin
          wp <= inc(wp);
        end
        if (pop) begin
          rp <= inc(rp);
        end
        level_out <= level_out + lv_up - lv_dn;
        nfr <= nfr + fr_up - fr_dn;
      end
    end
  end
endmodule

// >>> verif/rbeo_sva.sv
`timescale 1ns/100ps
module rbeo_sva (
  // Clock and reset
  input wire mclk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Register bus
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire [1:0] s_axi_bresp_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // Character path and power
  input wire rec_char_valid_in,
  input wire ref_char_tick_in,
  input wire rx_char_valid_out,
  input wire [2:0] rx_status_bits_out,
  input wire rx_pll_enable_out,
  input wire serial_driver1_enable_out,
  input wire serial_driver2_enable_out,
  input wire tx_logic_power_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence aw_take;
    s_axi_awvalid_in && s_axi_awready_out;
  endsequence
  sequence w_take;
    s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence ar_take;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  write_resp_a: assert property (aw_take ##0 w_take |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  read_resp_a: assert property (ar_take |=> s_axi_rvalid_out)
    else $error("read response late");
  bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  ready_gate_a: assert property (!ce_in |->
    !(s_axi_awready_out || s_axi_wready_out || s_axi_arready_out))
    else $error("ready while disabled");
  drv_power_a: assert property (tx_logic_power_out ==
    (serial_driver1_enable_out || serial_driver2_enable_out))
    else $error("transmit power wrong");
  out_latency_a: assert property (rx_char_valid_out |->
    $past(rec_char_valid_in, 2) || $past(ref_char_tick_in, 2))
    else $error("output load without cause");
  reset_state_a: assert property ($rose(rst_n_in) |-> !rx_pll_enable_out &&
    !tx_logic_power_out && rx_status_bits_out == 3'b000 && !rx_char_valid_out)
    else $error("state after reset wrong");
endmodule

// >>> verif/rbeo_far_tx.sv
`timescale 1ns/100ps
module rbeo_far_tx (
  // Clock
  input wire mclk_in,
  // Framed character stream
  output reg rec_char_valid_out,
  output reg [9:0] raw_char_bits_out,
  output reg [7:0] dec_data_out,
  output reg [2:0] dec_status_out,
  output reg char_boundary_out,
  output reg pll_locked_out
);
  initial begin
    rec_char_valid_out = 1'b0;
    raw_char_bits_out = 10'h000;
    dec_data_out = 8'h00;
    dec_status_out = 3'b000;
    char_boundary_out = 1'b0;
    pll_locked_out = 1'b1;
  end
  // Caller keeps framing chars dense; lines go stale after the strobe
  task send(input [9:0] raw, input [10:0] dec, input bnd);
    begin
      @(posedge mclk_in);
      rec_char_valid_out <= 1'b1;
      raw_char_bits_out <= raw;
      {dec_status_out, dec_data_out} <= dec;
      char_boundary_out <= bnd;
      @(posedge mclk_in);
      rec_char_valid_out <= 1'b0;
      raw_char_bits_out <= ~raw;
      {dec_status_out, dec_data_out} <= ~dec;
      char_boundary_out <= ~bnd;
    end
  endtask
endmodule

// >>> verif/testbench.sv
`timescale 1ns/100ps
`include "rbeo_consts.vh"
module testbench;
  reg mclk_in, rst_n_in, ce_in, ref_char_tick_in, ref_on;
  reg [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  reg [31:0] s_axi_wdata_in, rd;
  reg [3:0] s_axi_wstrb_in;
  reg s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  wire rec_char_valid_in, char_boundary_in, pll_locked_in, rx_char_valid_out;
  wire [9:0] raw_char_bits_in;
  wire [7:0] dec_data_in, rx_data_bits_out;
  wire [2:0] dec_status_in, rx_status_bits_out;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  wire s_axi_rvalid_out, rx_output_clock_out, framing_char_sel_out, framer_enable_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out, framer_mode_sel_out;
  wire [31:0] s_axi_rdata_out;
  wire rx_pll_enable_out, serial_driver1_enable_out, serial_driver2_enable_out;
  wire tx_logic_power_out;
  integer n_mismatch, cmp_count, i;
  reg [8:0] p;
  reg [1:0] rs, tdiv;
  reg [10:0] got;
  reg [10:0] q [$];
  reg [12:0] tv [0:5] = '{13'h1d7c, 13'h187c, 13'h0c7c, 13'h0283, 13'h1e83, 13'h0955};
  rbeo_rx_backend dut (.*);
  rbeo_far_tx far (.mclk_in(mclk_in), .rec_char_valid_out(rec_char_valid_in),
    .raw_char_bits_out(raw_char_bits_in), .dec_data_out(dec_data_in),
    .dec_status_out(dec_status_in), .char_boundary_out(char_boundary_in),
    .pll_locked_out(pll_locked_in));
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  function [10:0] ex(input [8:0] s);
    ex = (s[8] && s[7:4] == 4'hf) ? {3'b110, s[7:0]} : {2'b00, s[8], s[7:0]};
  endfunction
  task cmp(input string nm, input [31:0] e, input [31:0] a);
    begin
      cmp_count = cmp_count + 1;
      if (a !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %s expected %h seen %h", nm, e, a);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      do begin
        @(posedge mclk_in);
        if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
        if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (s_axi_awvalid_in && !s_axi_awready_out || s_axi_wvalid_in && !s_axi_wready_out);
      while (!s_axi_bvalid_out) @(posedge mclk_in);
      rs = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge mclk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do @(posedge mclk_in); while (!s_axi_arready_out);
      s_axi_arvalid_in <= 1'b0;
      do @(posedge mclk_in); while (!s_axi_rvalid_out);
      rd = s_axi_rdata_out;
      rs = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
    end
  endtask
  task xfer(input [9:0] raw, input [10:0] dec, input bnd);
    begin
      far.send(raw, dec, bnd);
      @(posedge mclk_in);
      #1;
      cmp("out_valid", 1, rx_char_valid_out);
      cmp("out_clock", 1, rx_output_clock_out);
      got = {rx_status_bits_out, rx_data_bits_out};
    end
  endtask
  task run_loop(input integer bad, input [2:0] fin);
    begin
      p = 9'h000;
      for (i = 0; i < 511; i = i + 1) begin
        xfer(10'h000, (i == bad) ? {3'b000, ~p[7:0]} : ex(p), 1'b1);
        if (i == 1 || i == 510) cmp("bist", (i == 1) ? 3'b001 : fin, got[10:8]);
        p = {p[7:0], ~(p[8] ^ p[4])};
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Reference character ticks, one every third cycle
  always @(posedge mclk_in) begin
    tdiv <= (!ref_on || tdiv == 2'd2) ? 2'd0 : tdiv + 2'd1;
    ref_char_tick_in <= ref_on && tdiv == 2'd2;
    if (ref_on && rx_char_valid_out && {rx_status_bits_out, rx_data_bits_out} !== `RBEO_FILL_DEC) begin
      cmp("ref_order", q[0], {rx_status_bits_out, rx_data_bits_out});
      void'(q.pop_front());
    end
  end
  initial begin
    #(5 * 40000);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    {rst_n_in, ref_char_tick_in, ref_on, tdiv} = 0;
    ce_in = 1'b1;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 0;
    s_axi_wstrb_in = 4'hf;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 0;
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd_reg(`RBEO_ADDR_CTRL);
    cmp("ctrl", `RBEO_CTRL_RESET, rd);
    rd_reg(`RBEO_ADDR_STATUS);
    cmp("level", `RBEO_EB_NOMINAL, rd[7:4]);
    rd_reg(8'h0c);
    cmp("decerr", 2'b11, rs);
    cmp("pwr_off", 0, {rx_pll_enable_out, tx_logic_power_out});
    ce_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    ce_in <= 1'b1;
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(`RBEO_ADDR_CTRL, {21'h0, i[1:0], 9'h102});
      cmp("tx_power", |i[1:0], tx_logic_power_out);
      cmp("pll", 1, rx_pll_enable_out);
    end
    for (i = 0; i < 4; i = i + 1) begin
      xfer(~i[9:0], {i[1], i[1], i[0], 8'h5a + i[7:0]}, 1'b1);
      cmp("decoded", {i[1], i[1], i[0], 8'h5a + i[7:0]}, got);
    end
    $display("test decode done");
    for (i = 0; i < 6; i = i + 1) begin
      wr(`RBEO_ADDR_CTRL, {21'h0, 3'h7, 5'h0, tv[i][12], 2'h0});
      xfer(tv[i][9:0], 11'h7ff, tv[i][11]);
      cmp("bypass", {tv[i][10], tv[i][0], tv[i][1], tv[i][9:2]}, got);
    end
    $display("test bypass done");
    wr(`RBEO_ADDR_CTRL, 32'h703);
    xfer(10'h000, `RBEO_FILL_DEC, 1'b1);
    run_loop(-1, `RBEO_BST_PASS);
    run_loop(5, `RBEO_BST_FAIL);
    rd_reg(`RBEO_ADDR_LOOPS);
    cmp("loops", 16'h0101, rd[15:0]);
    p = 9'h000;
    for (i = 0; i < 18; i = i + 1) begin
      xfer(10'h000, (i == 0) ? ex(p) : {3'b000, ~p[7:0]}, 1'b1);
      p = {p[7:0], ~(p[8] ^ p[4])};
      if (i == 16) begin
        rd_reg(`RBEO_ADDR_STATUS);
        cmp("margin", {`RBEO_ABORT_MARGIN, 6'h0, 2'd3}, {rd[12:8], rd[7:2] & 6'h0, rd[1:0]});
      end
    end
    rd_reg(`RBEO_ADDR_STATUS);
    cmp("abort", 2'd2, rd[1:0]);
    wr(`RBEO_ADDR_CTRL, 32'h702);
    rd_reg(`RBEO_ADDR_STATUS);
    cmp("bist_off", 2'd0, rd[1:0]);
    $display("test selftest done");
    wr(`RBEO_ADDR_CTRL, 32'h782);
    ref_on <= 1'b1;
    for (i = 0; i < 17; i = i + 1) begin
      if (i[0]) q.push_back({3'b000, 8'h10 + i[7:0]});
      far.send(i[0] ? 10'h000 : `RBEO_K285_A, i[0] ? {3'b000, 8'h10 + i[7:0]} : `RBEO_FILL_DEC, 1'b1);
    end
    repeat (60) @(posedge mclk_in);
    cmp("ref_drained", 0, q.size());
    ref_on <= 1'b0;
    $display("test elastic done");
    tally_and_finish;
  end
endmodule
bind rbeo_rx_backend rbeo_sva chk (.*);
